// ---- design/lin_brk_pkg.sv ----
// Purpose: Shared constants for the LIN break sender and interrupt enables
// Assumes: 32-bit APB register access, one word per register
// Notes: Offsets, field positions and the enables, length and divisor reset values live here
package lin_brk_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_BITDIV = 8'h08;

	// ----------------------------------------
	// Field positions of uart_lin_config and of the status register
	// ----------------------------------------
	localparam int BIT_LIN_EN = 23;
	localparam int BIT_ROLE = 22;
	localparam int BRK_LEN_LSB = 16;
	localparam int BRK_LEN_W = 3;
	localparam int BIT_GATE = 14;
	localparam int BIT_SEND_BRK = 13;
	localparam int BIT_GLOBAL_IE = 12;
	localparam int IRQ_SRC_N = 12;
	localparam int BIT_BRK_DONE = 10;
	localparam int BIT_BRK_BUSY = 13;

	// ----------------------------------------
	// Reset values and break timing
	// ----------------------------------------
	localparam logic [12:0] ENABLES_RESET = 13'h0000;
	localparam logic [2:0] BRK_LEN_RESET = 3'h0;
	localparam logic [15:0] BITDIV_RESET = 16'h28b1;
	localparam logic [4:0] BREAK_BASE_BITS = 5'h0d;
	localparam logic [4:0] RECESSIVE_BITS = 5'h01;

	typedef enum logic [1:0] {
		BRK_IDLE = 2'b00,
		BRK_DOM = 2'b01,
		BRK_REC = 2'b10
	} brk_state_e;
endpackage : lin_brk_pkg

// ---- design/bit_tick_gen.sv ----
// Purpose: Bit-time enable pulse from the system clock
// Assumes: Divisor is cycles per bit; zero is treated as one
// Notes: Restart realigns so the first bit after it is a full bit time
`timescale 1ns/1ps
module bit_tick_gen #(
	parameter int DIV_W = 16
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic restart_in,
	input wire logic [DIV_W-1:0] div_in,
	output logic tick_out
);
	logic [DIV_W-1:0] cnt_r;
	logic [DIV_W-1:0] cnt_nxt;
	logic [DIV_W-1:0] reload;

	always_comb begin
		reload = (div_in == '0) ? '0 : div_in - {{(DIV_W-1){1'b0}}, 1'b1};
		tick_out = !restart_in && (cnt_r == '0);
		if (restart_in || cnt_r == '0) begin
			cnt_nxt = reload;
		end else begin
			cnt_nxt = cnt_r - {{(DIV_W-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule : bit_tick_gen

// ---- design/break_sender.sv ----
// Purpose: Dominant-then-recessive break sequencer
// Assumes: tick_in is one pulse per bit time, realigned at start_in
// Notes: Length is latched at start so a config write cannot stretch a break
`timescale 1ns/1ps
module break_sender (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic start_in,
	input wire logic tick_in,
	input wire logic [2:0] len_in,
	output logic dominant_out,
	output logic busy_out,
	output logic done_out
);
	lin_brk_pkg::brk_state_e state_r, state_nxt;
	logic [4:0] bits_r, bits_nxt;
	logic [4:0] target_r, target_nxt;

	always_comb begin
		state_nxt = state_r;
		bits_nxt = bits_r;
		target_nxt = target_r;
		done_out = 1'b0;
		case (state_r)
			lin_brk_pkg::BRK_IDLE: begin
				if (start_in) begin
					state_nxt = lin_brk_pkg::BRK_DOM;
					bits_nxt = 5'h00;
					target_nxt = lin_brk_pkg::BREAK_BASE_BITS + {2'b00, len_in}; // see RQ2
				end
			end
			lin_brk_pkg::BRK_DOM: begin
				if (tick_in) begin
					bits_nxt = bits_r + 5'h01;
					if (bits_r + 5'h01 == target_r) begin
						state_nxt = lin_brk_pkg::BRK_REC;
						bits_nxt = 5'h00;
					end
				end
			end
			lin_brk_pkg::BRK_REC: begin
				if (tick_in) begin
					bits_nxt = bits_r + 5'h01;
					if (bits_r + 5'h01 == lin_brk_pkg::RECESSIVE_BITS) begin // see RQ2
						state_nxt = lin_brk_pkg::BRK_IDLE;
						done_out = 1'b1;
					end
				end
			end
			default: begin
				state_nxt = lin_brk_pkg::BRK_IDLE;
			end
		endcase
		dominant_out = (state_r == lin_brk_pkg::BRK_DOM);
		busy_out = (state_r != lin_brk_pkg::BRK_IDLE);
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			state_r <= lin_brk_pkg::BRK_IDLE;
			bits_r <= 5'h00;
			target_r <= 5'h00;
		end else begin
			state_r <= state_nxt;
			bits_r <= bits_nxt;
			target_r <= target_nxt;
		end
	end
endmodule : break_sender

// ---- design/lin_break_and_irq_enables.sv ----
// Purpose: LIN break-send command and interrupt enables of the serial port
// Assumes: APB3 slave, zero wait states; event inputs are one-cycle pulses
// Notes: The break waits for the byte in flight and holds the tx queue off
//
// Behaviour
// (RQ1) Break only when LIN enabled and master
// (RQ2) Send 13 plus length dominant, one recessive
// (RQ3) Command bit self-clears after the sequence
// (RQ4) Completion sets break-done, interrupts if enabled
// (RQ5) Queued bytes wait until break completes
// (RQ6) Command write-only, gated, zero ignored
// (RQ7) Gated write changes only the command
// (RQ8) Role select one means master
// (RQ9) Bit 12 global interrupt enable, reset zero
// (RQ10) Bit 11 enables idle timer interrupt
// (RQ11) Bit 9 enables sync-done interrupt
// (RQ12) Bits 8,7 enable tx overflow, full
// (RQ13) Bits 6,5 enable tx empty, ready
// (RQ14) Bits 4,3 enable rx overflow, underrun
// (RQ15) Bits 2,1,0 enable rx full, empty, ready
// (RQ16) Software commands break only in master mode
// (RQ17) Interrupt is global AND OR of enabled flags
`timescale 1ns/1ps
module lin_break_and_irq_enables #(
	parameter int ADDR_W = 8,
	parameter int DIV_W = 16
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [ADDR_W-1:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [11:0] event_pulse_in,
	input wire logic tx_busy_in,
	input wire logic tx_serial_in,
	output logic tx_hold_out,
	output logic lin_tx_out,
	output logic irq_out
);
	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	logic [7:0] addr;
	logic wr_acc;
	logic rd_setup;
	logic sel_config;
	logic sel_status;
	logic sel_bitdiv;
	logic addr_ok;

	always_comb begin
		addr = 8'(paddr_in);
		wr_acc = psel_in && penable_in && pwrite_in;
		rd_setup = psel_in && !penable_in && !pwrite_in;
		sel_config = (addr == lin_brk_pkg::OFF_CONFIG);
		sel_status = (addr == lin_brk_pkg::OFF_STATUS);
		sel_bitdiv = (addr == lin_brk_pkg::OFF_BITDIV);
		addr_ok = sel_config || sel_status || sel_bitdiv;
		pready_out = 1'b1;
		pslverr_out = psel_in && penable_in && !addr_ok;
	end

	// ----------------------------------------
	// Configuration and command state
	// ----------------------------------------
	logic lin_en_r, lin_en_nxt;
	logic role_r, role_nxt;
	logic [2:0] len_r, len_nxt;
	logic [12:0] enables_r, enables_nxt;
	logic [DIV_W-1:0] bitdiv_r, bitdiv_nxt;
	logic brk_req_r, brk_req_nxt;
	logic gated_wr;
	logic accept;
	logic brk_start;
	logic brk_dominant;
	logic brk_busy;
	logic brk_done;
	logic tick;

	always_comb begin
		lin_en_nxt = lin_en_r;
		role_nxt = role_r;
		len_nxt = len_r;
		enables_nxt = enables_r;
		bitdiv_nxt = bitdiv_r;
		gated_wr = wr_acc && sel_config && pwdata_in[lin_brk_pkg::BIT_GATE];
		// A gated write touches nothing but the command
		accept = gated_wr && pwdata_in[lin_brk_pkg::BIT_SEND_BRK] // see RQ6
			&& lin_en_r && role_r && !brk_req_r; // see RQ1 // see RQ8
		if (wr_acc && sel_config && !gated_wr) begin // see RQ7
			enables_nxt = pwdata_in[12:0]; // see RQ9 // see RQ10 // see RQ11
			len_nxt = pwdata_in[lin_brk_pkg::BRK_LEN_LSB +: lin_brk_pkg::BRK_LEN_W];
			lin_en_nxt = pwdata_in[lin_brk_pkg::BIT_LIN_EN];
			// Role is frozen while the LIN extension runs
			if (!lin_en_r) begin
				role_nxt = pwdata_in[lin_brk_pkg::BIT_ROLE]; // see RQ8
			end
		end
		if (wr_acc && sel_bitdiv) begin
			bitdiv_nxt = pwdata_in[DIV_W-1:0];
		end
		if (brk_done) begin
			brk_req_nxt = 1'b0; // see RQ3
		end else if (accept) begin
			brk_req_nxt = 1'b1;
		end else begin
			brk_req_nxt = brk_req_r;
		end
		// Start only between bytes so a byte in flight is never cut
		brk_start = brk_req_r && !brk_busy && !tx_busy_in;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			lin_en_r <= 1'b0;
			role_r <= 1'b0;
			len_r <= lin_brk_pkg::BRK_LEN_RESET;
			enables_r <= lin_brk_pkg::ENABLES_RESET; // see RQ12 // see RQ13
			bitdiv_r <= lin_brk_pkg::BITDIV_RESET;
			brk_req_r <= 1'b0;
		end else begin
			lin_en_r <= lin_en_nxt;
			role_r <= role_nxt;
			len_r <= len_nxt;
			enables_r <= enables_nxt; // see RQ14 // see RQ15
			bitdiv_r <= bitdiv_nxt;
			brk_req_r <= brk_req_nxt;
		end
	end

	// ----------------------------------------
	// Break sequencing
	// ----------------------------------------
	bit_tick_gen #(
		.DIV_W(DIV_W)
	) u_tick (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.restart_in(brk_start),
		.div_in(bitdiv_r),
		.tick_out(tick)
	);

	break_sender u_brk (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.start_in(brk_start),
		.tick_in(tick),
		.len_in(len_r),
		.dominant_out(brk_dominant),
		.busy_out(brk_busy),
		.done_out(brk_done)
	);

	logic lin_tx_r, lin_tx_nxt;

	always_comb begin
		lin_tx_nxt = brk_dominant ? 1'b0 : (brk_busy ? 1'b1 : tx_serial_in); // see RQ2
		tx_hold_out = brk_req_r; // see RQ5
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			lin_tx_r <= 1'b1;
		end else begin
			lin_tx_r <= lin_tx_nxt;
		end
	end

	// ----------------------------------------
	// Sticky events and interrupt
	// ----------------------------------------
	logic [11:0] status_r, status_nxt;
	logic [11:0] set_vec;
	logic [11:0] clr_vec;

	always_comb begin
		set_vec = event_pulse_in;
		set_vec[lin_brk_pkg::BIT_BRK_DONE] = brk_done; // see RQ4
		clr_vec = (wr_acc && sel_status) ? pwdata_in[11:0] : 12'h000;
		// Set wins over a same-cycle clear so no event is lost
		status_nxt = (status_r & ~clr_vec) | set_vec;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			status_r <= 12'h000;
		end else begin
			status_r <= status_nxt;
		end
	end

	always_comb begin
		irq_out = enables_r[lin_brk_pkg::BIT_GLOBAL_IE] // see RQ9
			&& |(status_r & enables_r[11:0]); // see RQ17 // see RQ4
	end

	// ----------------------------------------
	// Read data, captured in the setup phase
	// ----------------------------------------
	logic [31:0] rdata_r, rdata_nxt;

	always_comb begin
		rdata_nxt = rdata_r;
		if (rd_setup) begin
			rdata_nxt = 32'h0000_0000;
			if (sel_config) begin
				rdata_nxt[lin_brk_pkg::BIT_LIN_EN] = lin_en_r;
				rdata_nxt[lin_brk_pkg::BIT_ROLE] = role_r;
				rdata_nxt[lin_brk_pkg::BRK_LEN_LSB +: lin_brk_pkg::BRK_LEN_W] = len_r;
				rdata_nxt[12:0] = enables_r;
			end else if (sel_status) begin
				rdata_nxt[lin_brk_pkg::BIT_BRK_BUSY] = brk_req_r;
				rdata_nxt[11:0] = status_r;
			end else if (sel_bitdiv) begin
				rdata_nxt[DIV_W-1:0] = bitdiv_r;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	always_comb begin
		prdata_out = rdata_r;
		lin_tx_out = lin_tx_r;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	logic [31:0] dom_cyc_r;
	logic [31:0] rec_cyc_r;
	logic [31:0] exp_dom_r;
	logic [31:0] div_eff;

	always_comb begin
		div_eff = (bitdiv_r == '0) ? 32'h0000_0001 : 32'(bitdiv_r);
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in || brk_start) begin
			dom_cyc_r <= 32'h0000_0000;
			rec_cyc_r <= 32'h0000_0000;
			exp_dom_r <= 32'({2'b00, len_r} + lin_brk_pkg::BREAK_BASE_BITS) * div_eff;
		end else begin
			if (brk_dominant) begin
				dom_cyc_r <= dom_cyc_r + 32'h0000_0001;
			end
			if (brk_busy && !brk_dominant) begin
				rec_cyc_r <= rec_cyc_r + 32'h0000_0001;
			end
		end
	end

	sequence gated_send_s;
		wr_acc && sel_config && pwdata_in[lin_brk_pkg::BIT_GATE];
	endsequence

	chk_cmd_needs_master: assert property ($rose(brk_req_r) |-> $past(lin_en_r && role_r)) // see RQ1
		else $error("break accepted outside LIN master mode");
	chk_zero_ignored: assert property ( // see RQ6
		gated_send_s ##0 (!pwdata_in[lin_brk_pkg::BIT_SEND_BRK] && !brk_req_r)
		|=> !brk_req_r)
		else $error("writing zero to the send-break bit started a break");
	chk_gate_keeps_cfg: assert property (gated_send_s |=> // see RQ7
		$stable(enables_r) && $stable(len_r) && $stable(lin_en_r) && $stable(role_r))
		else $error("gated write altered configuration fields");
	chk_dom_length: assert property ($fell(brk_dominant) |-> dom_cyc_r == exp_dom_r) // see RQ2
		else $error("dominant break length wrong");
	chk_rec_one_bit: assert property (brk_done |-> rec_cyc_r + 32'h0000_0001 == div_eff) // see RQ2
		else $error("recessive tail is not one bit time");
	chk_self_clear: assert property (brk_done |=> !brk_req_r && !tx_hold_out) // see RQ3
		else $error("send-break bit not cleared after sequence");
	chk_done_flag: assert property (brk_done |=> status_r[lin_brk_pkg::BIT_BRK_DONE]) // see RQ4
		else $error("break completion flag not set");
	chk_tx_deferred: assert property (brk_busy |-> tx_hold_out) // see RQ5
		else $error("tx queue not held during break");
	chk_line_dominant: assert property (brk_dominant |=> !lin_tx_out) // see RQ2
		else $error("line not dominant during break");
	chk_global_gate: assert property (!enables_r[lin_brk_pkg::BIT_GLOBAL_IE] |-> !irq_out) // see RQ9
		else $error("interrupt raised with global enable clear");
	chk_irq_combine: assert property ( // see RQ17
		irq_out == (enables_r[12] && |(status_r & enables_r[11:0])))
		else $error("interrupt output does not match enabled flags");
	chk_role_frozen: assert property (lin_en_r && $past(lin_en_r) |-> $stable(role_r)) // see RQ8
		else $error("role select changed while LIN enabled");
endmodule : lin_break_and_irq_enables

// ---- tb/tx_model.sv ----
// Purpose: Normal byte transmitter standing beside the break block
// Assumes: go_in is a level meaning a byte is queued
// Notes: Serial output toggles while busy, idle high
`timescale 1ns/1ps
module tx_model #(
	parameter int BYTE_CYC = 12
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic go_in,
	input wire logic hold_in,
	output logic busy_out,
	output logic serial_out
);
	logic [4:0] cnt_r;
	logic [4:0] cnt_nxt;
	always_comb begin
		cnt_nxt = cnt_r;
		if (cnt_r != 5'h00)
			cnt_nxt = cnt_r - 5'h01;
		else if (go_in && !hold_in)
			cnt_nxt = 5'(BYTE_CYC);
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			cnt_r <= 5'h00;
		else
			cnt_r <= cnt_nxt;
	end
	assign busy_out = (cnt_r != 5'h00);
	assign serial_out = busy_out ? cnt_r[0] : 1'b1;
endmodule : tx_model

// ---- tb/tb_top.sv ----
// Purpose: Self-checking bench for the break sender and interrupt enables
// Assumes: Zero-wait APB, divisor shortened to 2 cycles per bit
// Notes: Scenarios run in sequence after one reset
`timescale 1ns/1ps
module tb_top;
	logic clk_in = 0;
	logic rst_n_in = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic go = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [11:0] ev = 12'h000;
	logic [31:0] rd, prdata;
	logic err, pready, pslverr, hold, lin_tx, irq, busy, ser;
	int error_cnt = 0;
	int comparisons = 0;
	localparam logic [31:0] CFG = 32'h00c51400;
	always #2.5 clk_in = ~clk_in;
	lin_break_and_irq_enables lin_break_and_irq_enables_inst (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .event_pulse_in(ev), .tx_busy_in(busy),
		.tx_serial_in(ser), .tx_hold_out(hold), .lin_tx_out(lin_tx), .irq_out(irq));
	tx_model tx_model_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .go_in(go),
		.hold_in(hold), .busy_out(busy), .serial_out(ser));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			error_cnt++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk_in);
	endtask : apb
	task automatic pulse(input int i);
		ev <= 12'h001 << i;
		@(posedge clk_in);
		ev <= 12'h000;
		@(posedge clk_in);
	endtask : pulse
	task automatic send_none;
		apb(1, 8'h00, 32'h00006000);
		repeat (3) @(posedge clk_in);
		chk(hold, 0, "hold");
		apb(0, 8'h04, 0);
		chk(rd, 0, "status");
	endtask : send_none
	task stop_test;
		$display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		chk({irq, lin_tx, hold}, 3'b010, "pins");
		chk(pready, 1, "ready");
		apb(0, 8'h00, 0);
		chk(rd, 0, "config");
		apb(0, 8'h08, 0);
		chk(rd, 32'h28b1, "divisor");
		apb(0, 8'h0c, 0);
		chk(err, 1, "unmapped error");
		chk(rd, 0, "unmapped data");
	endtask : t_reset
	task automatic t_enables;
		apb(1, 8'h00, 32'h00001fff);
		apb(1, 8'h00, 32'h00004000);
		apb(0, 8'h00, 0);
		chk(rd, 32'h1fff, "enables");
	endtask : t_enables
	task automatic t_irq;
		for (int i = 0; i < 12; i++) begin
			if (i != 10) begin
				pulse(i);
				chk(irq, 1, "irq set");
				apb(0, 8'h04, 0);
				chk(rd, 32'h1 << i, "flag");
				apb(1, 8'h04, 32'h1 << i);
				chk(irq, 0, "irq clear");
			end
		end
		apb(1, 8'h00, 32'h00000fff);
		pulse(0);
		chk(irq, 0, "global off");
		apb(1, 8'h00, 32'h00001ffe);
		chk(irq, 0, "masked");
		apb(1, 8'h00, 32'h00001fff);
		chk(irq, 1, "unmasked");
		apb(1, 8'h04, 32'h1);
	endtask : t_irq
	task automatic t_refuse;
		apb(1, 8'h00, 32'h00400000);
		send_none;
		apb(1, 8'h00, 0);
		apb(1, 8'h00, 32'h00800000);
		apb(1, 8'h00, 32'h00c00000);
		apb(0, 8'h00, 0);
		chk(rd, 32'h00800000, "role frozen");
		send_none;
		apb(1, 8'h00, 0);
	endtask : t_refuse
	task automatic t_break;
		int n = 0;
		logic bad = 0;
		apb(1, 8'h08, 32'h2);
		apb(1, 8'h00, 32'h00451400);
		apb(1, 8'h00, CFG);
		apb(1, 8'h00, 32'h00004000);
		chk(hold, 0, "gate only");
		go <= 1;
		while (busy !== 1'b1 && n < 50) begin
			@(posedge clk_in);
			n++;
		end
		chk(busy, 1, "byte start");
		apb(1, 8'h00, 32'h00006000);
		chk(hold, 1, "hold");
		apb(0, 8'h00, 0);
		chk(rd, CFG, "config kept");
		n = 0;
		while ((busy === 1'b1 || lin_tx !== 1'b0) && n < 100) begin
			@(posedge clk_in);
			n++;
		end
		n = 0;
		while (lin_tx === 1'b0 && n < 200) begin
			@(posedge clk_in);
			n++;
			bad |= busy;
		end
		chk(n, 36, "dominant cycles");
		n = 0;
		while (hold === 1'b1 && n < 100) begin
			@(posedge clk_in);
			n++;
			bad |= busy;
		end
		chk(hold, 0, "hold released");
		chk({bad, lin_tx}, 2'b01, "byte held");
		apb(0, 8'h04, 0);
		chk(rd, 32'h400, "break done");
		chk(irq, 1, "break irq");
		n = 0;
		while (busy !== 1'b1 && n < 10) begin
			@(posedge clk_in);
			n++;
		end
		chk(busy, 1, "byte after");
		go <= 0;
		apb(1, 8'h04, 32'h400);
		chk(irq, 0, "irq clear");
	endtask : t_break
	initial begin
		repeat (20) @(posedge clk_in);
		rst_n_in <= 1;
		@(posedge clk_in);
		t_reset;
		t_enables;
		t_irq;
		t_refuse;
		t_break;
		stop_test;
	end
	initial begin
		#100us;
		error_cnt++;
		stop_test;
	end
endmodule : tb_top
